// ===== dpsr_regs.sv
// ahb-lite register bank for receive/transmit descriptor ring pointers
//
// The implementer's own choices: the AHB-Lite slave port and the register offsets.
`timescale 1ns/100ps
// Summary of operation
// R1: next receive pointer keeps address of next receive ring entry in bits 23-0.
// R2: upper bits 31-24 of 24-bit pointers written zero; read value undefined (zero here).
// R3: current receive pointer keeps address of receive ring entry in use, bits 23-0.
// R4: next-next receive pointer is a full 32-bit pointer, two entries ahead.
// R5: next-next transmit pointer is a full 32-bit pointer, two entries ahead.
// R6: current receive status copies bits 15:8 of current receive descriptor word 1.
// R7: software touches pointers and status only while stop or suspend is set.
// R8: pointer and status writes while neither stop nor suspend is set are dropped; pointers stay unchanged.
module dpsr_regs (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic eng_wr,
   input wire dpsr_pkg::dpsr_sel_t eng_sel,
   input wire logic [31:0] eng_wdata,
   input wire logic eng_stat_load,
   input wire logic [15:0] rx_descriptor_word1,
   output logic [23:0] next_rx_desc_ptr,
   output logic [23:0] current_rx_desc_ptr,
   output logic [31:0] next_next_rx_desc_ptr,
   output logic [31:0] next_next_tx_desc_ptr,
   output logic [7:0] current_rx_status_copy,
   output logic stop_bit,
   output logic suspend_bit
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic [23:0] nrx_r, nrx_nxt;
   logic [23:0] crx_r, crx_nxt;
   logic [31:0] nnrx_r, nnrx_nxt;
   logic [31:0] nntx_r, nntx_nxt;
   logic [7:0] rxstat_r, rxstat_nxt;
   logic stop_r, stop_nxt;
   logic susp_r, susp_nxt;
   logic wpend_r, wpend_nxt;
   logic [7:0] waddr_r, waddr_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic rdy_r, rdy_nxt;
   logic addr_take;
   logic sw_open;
   logic sw_wr;

   function automatic logic wr_hit(input logic pend, input logic [7:0] a, input logic [7:0] o);
      wr_hit = pend && (a == o);
   endfunction

   // ------------------------------------------------------------
   // next-state logic
   // ------------------------------------------------------------
   always_comb begin
      addr_take = hsel && hready && (htrans == dpsr_pkg::HTRANS_NONSEQ);
      // pointers are only safe to touch while the engine is parked
      sw_open = stop_r || susp_r; // see R7
      sw_wr = wpend_r && sw_open; // see R8
      wpend_nxt = addr_take && hwrite;
      waddr_nxt = addr_take ? haddr[dpsr_pkg::ADDR_W-1:0] : waddr_r;
      rdy_nxt = 1'b1;
      stop_nxt = stop_r;
      susp_nxt = susp_r;
      if (wr_hit(wpend_r, waddr_r, dpsr_pkg::OFS_CTRL)) begin
         stop_nxt = hwdata[dpsr_pkg::CTRL_STOP_BIT];
         susp_nxt = hwdata[dpsr_pkg::CTRL_SUSP_BIT];
      end
      nrx_nxt = nrx_r;
      crx_nxt = crx_r;
      nnrx_nxt = nnrx_r;
      nntx_nxt = nntx_r;
      rxstat_nxt = rxstat_r;
      // upper bits of a 24-bit pointer are not stored at all
      if (wr_hit(sw_wr, waddr_r, dpsr_pkg::OFS_NRX)) begin
         nrx_nxt = hwdata[dpsr_pkg::PTR24_W-1:0]; // see R1, R2
      end
      if (wr_hit(sw_wr, waddr_r, dpsr_pkg::OFS_CRX)) begin
         crx_nxt = hwdata[dpsr_pkg::PTR24_W-1:0]; // see R3, R2
      end
      if (wr_hit(sw_wr, waddr_r, dpsr_pkg::OFS_NNRX)) begin
         nnrx_nxt = hwdata; // see R4
      end
      if (wr_hit(sw_wr, waddr_r, dpsr_pkg::OFS_NNTX)) begin
         nntx_nxt = hwdata; // see R5
      end
      if (wr_hit(sw_wr, waddr_r, dpsr_pkg::OFS_RXSTAT)) begin
         rxstat_nxt = hwdata[dpsr_pkg::RXSTAT_LSB +: dpsr_pkg::STAT_W];
      end
      // engine updates win over a software write in the same cycle
      if (eng_wr) begin
         unique case (eng_sel)
            dpsr_pkg::DPSR_SEL_NRX: begin
               nrx_nxt = eng_wdata[dpsr_pkg::PTR24_W-1:0]; // see R1
            end
            dpsr_pkg::DPSR_SEL_CRX: begin
               crx_nxt = eng_wdata[dpsr_pkg::PTR24_W-1:0]; // see R3
            end
            dpsr_pkg::DPSR_SEL_NNRX: begin
               nnrx_nxt = eng_wdata; // see R4
            end
            dpsr_pkg::DPSR_SEL_NNTX: begin
               nntx_nxt = eng_wdata; // see R5
            end
         endcase
      end
      if (eng_stat_load) begin
         rxstat_nxt = rx_descriptor_word1[dpsr_pkg::WORD1_STAT_LSB +: dpsr_pkg::STAT_W]; // see R6
      end
      // read data built from next values so a read right after a write sees it
      rdata_nxt = 32'h00000000;
      if (addr_take && !hwrite) begin
         unique case (haddr[dpsr_pkg::ADDR_W-1:0])
            dpsr_pkg::OFS_CTRL: begin
               rdata_nxt[dpsr_pkg::CTRL_STOP_BIT] = stop_nxt;
               rdata_nxt[dpsr_pkg::CTRL_SUSP_BIT] = susp_nxt;
            end
            dpsr_pkg::OFS_NRX: begin
               rdata_nxt[dpsr_pkg::PTR24_W-1:0] = nrx_nxt; // see R2
            end
            dpsr_pkg::OFS_CRX: begin
               rdata_nxt[dpsr_pkg::PTR24_W-1:0] = crx_nxt; // see R2
            end
            dpsr_pkg::OFS_NNRX: begin
               rdata_nxt = nnrx_nxt;
            end
            dpsr_pkg::OFS_NNTX: begin
               rdata_nxt = nntx_nxt;
            end
            dpsr_pkg::OFS_RXSTAT: begin
               rdata_nxt[dpsr_pkg::RXSTAT_LSB +: dpsr_pkg::STAT_W] = rxstat_nxt;
            end
            default: begin
               rdata_nxt = 32'h00000000;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         nrx_r <= dpsr_pkg::PTR24_RST;
         crx_r <= dpsr_pkg::PTR24_RST;
         nnrx_r <= dpsr_pkg::PTR32_RST;
         nntx_r <= dpsr_pkg::PTR32_RST;
         rxstat_r <= dpsr_pkg::STAT_RST;
         stop_r <= dpsr_pkg::STOP_RST;
         susp_r <= dpsr_pkg::SUSP_RST;
         wpend_r <= 1'b0;
         waddr_r <= 8'h00;
         rdata_r <= 32'h00000000;
         rdy_r <= 1'b1;
      end else begin
         nrx_r <= nrx_nxt;
         crx_r <= crx_nxt;
         nnrx_r <= nnrx_nxt;
         nntx_r <= nntx_nxt;
         rxstat_r <= rxstat_nxt;
         stop_r <= stop_nxt;
         susp_r <= susp_nxt;
         wpend_r <= wpend_nxt;
         waddr_r <= waddr_nxt;
         rdata_r <= rdata_nxt;
         rdy_r <= rdy_nxt;
      end
   end

   assign hrdata = rdata_r;
   assign hreadyout = rdy_r;
   assign hresp = 1'b0;
   assign next_rx_desc_ptr = nrx_r;
   assign current_rx_desc_ptr = crx_r;
   assign next_next_rx_desc_ptr = nnrx_r;
   assign next_next_tx_desc_ptr = nntx_r;
   assign current_rx_status_copy = rxstat_r;
   assign stop_bit = stop_r;
   assign suspend_bit = susp_r;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   a_nrx_sw_write: assert property ( // see R1
      wr_hit(sw_wr, waddr_r, dpsr_pkg::OFS_NRX) && !eng_wr
      |=> next_rx_desc_ptr == $past(hwdata[23:0]))
      else $error("next rx pointer not written");
   a_upper_reads_zero: assert property ( // see R2
      addr_take && !hwrite && (haddr[7:0] == dpsr_pkg::OFS_NRX || haddr[7:0] == dpsr_pkg::OFS_CRX)
      |=> hrdata[31:24] == 8'h00)
      else $error("pointer upper bits not zero");
   a_crx_engine_load: assert property ( // see R3
      eng_wr && eng_sel == dpsr_pkg::DPSR_SEL_CRX
      |=> current_rx_desc_ptr == $past(eng_wdata[23:0]))
      else $error("current rx pointer not loaded");
   a_nnrx_read_back: assert property ( // see R4
      wr_hit(sw_wr, waddr_r, dpsr_pkg::OFS_NNRX) && !eng_wr ##1
      (addr_take && !hwrite && haddr[7:0] == dpsr_pkg::OFS_NNRX && !eng_wr)
      |=> hrdata == $past(hwdata, 2))
      else $error("next-next rx pointer read back wrong");
   a_nntx_full_word: assert property ( // see R5
      eng_wr && eng_sel == dpsr_pkg::DPSR_SEL_NNTX
      |=> next_next_tx_desc_ptr == $past(eng_wdata))
      else $error("next-next tx pointer not full word");
   a_status_copy: assert property ( // see R6
      eng_stat_load |=> current_rx_status_copy == $past(rx_descriptor_word1[15:8]))
      else $error("rx status copy wrong");
   a_ptr_change_cause: assert property ( // see R7
      !$stable(next_next_rx_desc_ptr)
      |-> $past(eng_wr) || ($past(wpend_r) && ($past(stop_r) || $past(susp_r))))
      else $error("pointer changed without cause");
   a_blocked_write: assert property ( // see R8
      wpend_r && !stop_r && !susp_r && !eng_wr && !eng_stat_load
      |=> $stable(next_rx_desc_ptr) && $stable(current_rx_desc_ptr)
          && $stable(next_next_rx_desc_ptr) && $stable(next_next_tx_desc_ptr)
          && $stable(current_rx_status_copy))
      else $error("write while running changed a register");
endmodule

// ===== dpsr_pkg.sv
// constants and types shared by the descriptor pointer shadow registers
package dpsr_pkg;
   // ------------------------------------------------------------
   // register byte offsets
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_NRX = 8'h04;
   localparam logic [7:0] OFS_CRX = 8'h08;
   localparam logic [7:0] OFS_NNRX = 8'h0c;
   localparam logic [7:0] OFS_NNTX = 8'h10;
   localparam logic [7:0] OFS_RXSTAT = 8'h14;
   localparam int ADDR_W = 8;
   // ------------------------------------------------------------
   // field layout
   // ------------------------------------------------------------
   localparam int PTR24_W = 24;
   localparam int PTR32_W = 32;
   localparam int STAT_W = 8;
   localparam int CTRL_STOP_BIT = 0;
   localparam int CTRL_SUSP_BIT = 1;
   localparam int RXSTAT_LSB = 24;
   localparam int WORD1_STAT_LSB = 8;
   localparam int WORD1_W = 16;
   // ------------------------------------------------------------
   // reset values and the NONSEQ transfer code
   // ------------------------------------------------------------
   localparam logic [23:0] PTR24_RST = 24'h000000;
   localparam logic [31:0] PTR32_RST = 32'h00000000;
   localparam logic [7:0] STAT_RST = 8'h00;
   localparam logic STOP_RST = 1'b1;
   localparam logic SUSP_RST = 1'b0;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   // engine-side register select
   typedef enum logic [1:0] {
      DPSR_SEL_NRX,
      DPSR_SEL_CRX,
      DPSR_SEL_NNRX,
      DPSR_SEL_NNTX
   } dpsr_sel_t;
endpackage

// ===== tb_dpsr_regs.sv
// self-checking bench for the descriptor pointer shadow registers
`timescale 1ns/100ps
module tb_dpsr_regs;
   // ------------------------------------------------------------
   // stimulus and observed signals
   // ------------------------------------------------------------
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic eng_wr = 1'b0;
   logic eng_stat_load = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] eng_wdata = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [15:0] word1 = 16'h0;
   dpsr_pkg::dpsr_sel_t eng_sel = dpsr_pkg::DPSR_SEL_NRX;
   wire logic [31:0] hrdata;
   wire logic hreadyout, hresp, stop_bit, suspend_bit, hready;
   wire logic [23:0] nrx, crx;
   wire logic [31:0] nnrx, nntx;
   wire logic [7:0] rxstat;
   int n_mismatch = 0;
   int n_compared = 0;
   logic [31:0] rd;
   logic [31:0] cur [4];
   logic [31:0] msk [4] = '{32'h00ffffff, 32'h00ffffff, 32'hffffffff, 32'hffffffff};
   assign hready = hreadyout;
   always #5 mclk = ~mclk;
   dpsr_regs dpsr_regs_inst (.mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .eng_wr(eng_wr),
      .eng_sel(eng_sel), .eng_wdata(eng_wdata), .eng_stat_load(eng_stat_load),
      .rx_descriptor_word1(word1), .next_rx_desc_ptr(nrx), .current_rx_desc_ptr(crx),
      .next_next_rx_desc_ptr(nnrx), .next_next_tx_desc_ptr(nntx),
      .current_rx_status_copy(rxstat), .stop_bit(stop_bit), .suspend_bit(suspend_bit));
   // ------------------------------------------------------------
   // bus, engine and compare tasks
   // ------------------------------------------------------------
   function automatic logic [31:0] ofs(input int i);
      return {24'h0, dpsr_pkg::OFS_NRX} + 32'(4 * i);
   endfunction
   function automatic logic [31:0] port_of(input int i);
      return (i == 0) ? {8'h0, nrx} : (i == 1) ? {8'h0, crx} : (i == 2) ? nnrx : nntx;
   endfunction
   task automatic check32(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // a transfer holds each phase until hready is seen high at an edge
   // called right after a rising edge, so back to back calls leave no idle cycle
   task automatic ahb_xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= wr;
      htrans <= dpsr_pkg::HTRANS_NONSEQ;
      @(posedge mclk);
      while (hready !== 1'b1) @(posedge mclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge mclk);
      while (hready !== 1'b1) @(posedge mclk);
      rd = hrdata;
      check32("hresp", 32'h0, {31'h0, hresp});
   endtask
   task automatic ahb_write(input logic [31:0] a, input logic [31:0] d);
      ahb_xfer(1'b1, a, d);
   endtask
   task automatic ahb_read_chk(input string nm, input logic [31:0] a, input logic [31:0] e);
      ahb_xfer(1'b0, a, 32'h0);
      check32(nm, e, rd);
   endtask
   task automatic eng_load(input int i, input logic [31:0] d);
      @(posedge mclk);
      eng_wr <= 1'b1;
      eng_sel <= dpsr_pkg::dpsr_sel_t'(i[1:0]);
      eng_wdata <= d;
      @(posedge mclk);
      eng_wr <= 1'b0;
      cur[i] = d & msk[i];
   endtask
   // pointers written by software land only while stopped or suspended
   task automatic write_all(input logic [31:0] base, input logic lands);
      for (int i = 0; i < 4; i++) begin
         ahb_write(ofs(i), (base ^ 32'(i * 32'h01111111)) & msk[i]);
         if (lands) cur[i] = (base ^ 32'(i * 32'h01111111)) & msk[i];
      end
      for (int i = 0; i < 4; i++) begin
         ahb_read_chk("ptr read", ofs(i), cur[i]);
         check32("ptr port", cur[i], port_of(i));
      end
   endtask
   task automatic finish_test();
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   initial begin
      repeat (20000) @(posedge mclk);
      n_mismatch++;
      finish_test();
   end
   initial begin
      for (int i = 0; i < 4; i++) cur[i] = 32'h0;
      repeat (6) @(posedge mclk);
      rst_n <= 1'b1;
      ahb_read_chk("ctrl reset", {24'h0, dpsr_pkg::OFS_CTRL}, 32'h1);
      check32("stop port", 32'h1, {31'h0, stop_bit});
      for (int i = 0; i < 4; i++) begin
         ahb_read_chk("ptr reset", ofs(i), dpsr_pkg::PTR32_RST);
      end
      write_all(32'h0, 1'b1);
      $display("test reset done");
      write_all(32'hf1a2b3c4, 1'b1);
      $display("test stopped done");
      word1 <= 16'hab5c;
      @(posedge mclk);
      eng_stat_load <= 1'b1;
      @(posedge mclk);
      eng_stat_load <= 1'b0;
      ahb_read_chk("status", {24'h0, dpsr_pkg::OFS_RXSTAT}, 32'hab000000);
      check32("status port", 32'hab, {24'h0, rxstat});
      $display("test status done");
      ahb_write({24'h0, dpsr_pkg::OFS_CTRL}, 32'h0);
      ahb_read_chk("ctrl run", {24'h0, dpsr_pkg::OFS_CTRL}, 32'h0);
      write_all(32'h0e5d4c3b, 1'b0);
      ahb_write({24'h0, dpsr_pkg::OFS_RXSTAT}, 32'h11000000);
      ahb_read_chk("status run", {24'h0, dpsr_pkg::OFS_RXSTAT}, 32'hab000000);
      eng_load(3, 32'h13572468);
      eng_load(1, 32'hee654321);
      write_all(32'h0e5d4c3b, 1'b0);
      $display("test running done");
      ahb_write({24'h0, dpsr_pkg::OFS_CTRL}, 32'h2);
      // control bits settle one edge after the data phase
      @(posedge mclk);
      check32("ctrl ports", 32'h2, {30'h0, suspend_bit, stop_bit});
      write_all(32'h8d9e0f17, 1'b1);
      ahb_write(ofs(2), 32'h2468ace1);
      ahb_read_chk("nnrx back to back", ofs(2), 32'h2468ace1);
      $display("test suspend done");
      ahb_write(32'h00000040, 32'hdeadbeef);
      ahb_read_chk("unmapped", 32'h00000040, 32'h0);
      $display("test unmapped done");
      finish_test();
   end
endmodule
